// *** hdl/icfg_pkg.sv ***
/*
 Shared constants and carrier types for the two-wire configuration port
 with its bus-hang watchdog and non-volatile store/restore sequencer.
 Assumes a single 50 MHz system clock for all users of this package.
*/
package icfg_pkg;

   // System clock rate and the watchdog periods in milliseconds.
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned WD_SHORT_MS = 30;
   localparam int unsigned WD_P0_MS = 800;
   localparam int unsigned WD_P1_MS = 1600;
   localparam int unsigned WD_SHORT_CYC = CLK_HZ / 1000 * WD_SHORT_MS;
   localparam int unsigned WD_P0_CYC = CLK_HZ / 1000 * WD_P0_MS;
   localparam int unsigned WD_P1_CYC = CLK_HZ / 1000 * WD_P1_MS;
   localparam int WD_CNT_W = 27;

   // Target address: fixed upper bits, strap supplies the low two.
   localparam logic [6:0] TGT_ADDR_BASE = 7'h20;
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   // Register offsets.
   localparam logic [7:0] OFS_WATCHDOG = 8'hdf;
   localparam logic [7:0] OFS_NV_STATUS = 8'hec;
   localparam logic [7:0] OFS_SAVE_CMD = 8'hed;
   localparam logic [7:0] OFS_RAIL_SEL = 8'hef;
   localparam logic [7:0] OFS_PART = 8'hfb;
   localparam logic [7:0] OFS_VARIANT = 8'hfc;

   // Field positions, reset values and masks.
   localparam int WD_HANG_BIT = 7;
   localparam int WD_EN_BIT = 1;
   localparam int WD_PER_BIT = 0;
   localparam logic [1:0] WD_CFG_RST = 2'h3;
   localparam logic [7:0] RAIL_SEL_RST = 8'h03;
   localparam logic [7:0] RAIL_SEL_MASK = 8'h07;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // Selector values: common settings and the three rails.
   localparam logic [7:0] RAIL_COMMON = 8'h02;
   localparam logic [7:0] RAIL_A = 8'h03;
   localparam logic [7:0] RAIL_B = 8'h04;
   localparam logic [7:0] RAIL_C = 8'h05;

   // Store/restore command codes.
   localparam logic [7:0] CMD_RESTORE = 8'h66;
   localparam logic [7:0] CMD_STORE = 8'haa;

   // Request towards the non-volatile memory macro.
   typedef struct packed {
      logic req;
      logic write;
      logic [7:0] data;
   } icfg_nvm_req_t;

   // Answer from the non-volatile memory macro.
   typedef struct packed {
      logic ack;
      logic [7:0] data;
      logic [1:0] check_fail;
      logic store_allow;
   } icfg_nvm_rsp_t;

endpackage : icfg_pkg

// *** hdl/icfg_nvm_seq.sv ***
/*
 Store/restore sequencer: runs the power-up restore, decodes host
 commands and keeps the non-volatile status byte.
 Assumes the memory macro answers each held request with a one-cycle
 acknowledge on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module icfg_nvm_seq
   import icfg_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Command from the register file.
   input wire logic cmd_stb_i,
   input wire logic [7:0] cmd_code_i,
   input wire logic [1:0] cur_cfg_i,
   // Memory macro.
   input wire icfg_pkg::icfg_nvm_rsp_t rsp_i,
   output icfg_pkg::icfg_nvm_req_t req_o,
   // Results.
   output logic [7:0] status_o,
   output logic load_o,
   output logic [1:0] load_cfg_o,
   output logic [1:0] dflt_o
);

   typedef enum logic [3:0] {
      SQ_BOOT = 4'b0001,
      SQ_IDLE = 4'b0010,
      SQ_REST = 4'b0100,
      SQ_STOR = 4'b1000
   } icfg_seq_t;

   icfg_seq_t st_r;
   logic rest_done_r, stor_done_r;
   logic [1:0] fail_r;

   // Command decode; undefined codes match neither.
   wire is_rest = cmd_stb_i && (cmd_code_i == CMD_RESTORE);
   wire is_stor = cmd_stb_i && (cmd_code_i == CMD_STORE);

   // Status byte assembled from the sequencer's flops and the memory's store_allow.
   assign status_o = {rest_done_r, stor_done_r, rsp_i.store_allow,
                      st_r == SQ_REST, st_r == SQ_STOR,
                      fail_r, |fail_r};

   // The power-up restore reuses the host restore path.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= SQ_BOOT;
         rest_done_r <= 1'b0;
         stor_done_r <= 1'b0;
         fail_r <= 2'h0;
         req_o <= '0;
         load_o <= 1'b0;
         load_cfg_o <= WD_CFG_RST;
         dflt_o <= WD_CFG_RST;
      end else begin
         load_o <= 1'b0;
         case (st_r)
            SQ_BOOT, SQ_REST: begin
               req_o <= '{req: 1'b1, write: 1'b0, data: ZERO_BYTE};
               if (rsp_i.ack) begin
                  req_o <= '0;
                  load_o <= 1'b1;
                  load_cfg_o <= rsp_i.data[1:0];
                  dflt_o <= rsp_i.data[1:0];
                  fail_r <= rsp_i.check_fail;
                  rest_done_r <= (st_r == SQ_REST);
                  st_r <= SQ_IDLE;
               end
            end
            SQ_IDLE: begin
               if (is_rest) begin
                  rest_done_r <= 1'b0;
                  stor_done_r <= 1'b0;
                  st_r <= SQ_REST;
               end else if (is_stor && rsp_i.store_allow) begin
                  rest_done_r <= 1'b0;
                  stor_done_r <= 1'b0;
                  req_o <= '{req: 1'b1, write: 1'b1,
                             data: {6'h00, cur_cfg_i}};
                  st_r <= SQ_STOR;
               end
            end
            SQ_STOR: begin
               if (rsp_i.ack) begin
                  req_o <= '0;
                  stor_done_r <= 1'b1;
                  dflt_o <= req_o.data[1:0];
                  st_r <= SQ_IDLE;
               end
            end
            default: st_r <= SQ_IDLE;
         endcase
      end
   end

endmodule : icfg_nvm_seq
`default_nettype wire

// *** hdl/icfg_port.sv ***
/*
 Two-wire target configuration port: bit engine, register file,
 bus-hang watchdog and the store/restore sequencer instance.
 Assumes an external open-drain wire built from SDA_OE_O, and a host
 that paces every bit; the serial clock is only ever an input.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Answer at one of four addresses picked by the strap pins.
// - Never hold the serial clock low; the clock is input only.
// - Work at standard and fast bus rates; host stays within fast mode.
// - Watchdog top bit flags a stalled transaction, zero in normal traffic.
// - Enable clear: 30 ms stall resets only the serial state machine.
// - Enable set: stall past timeout restores watchdog settings and selector to defaults.
// - Period bit picks 800 ms when zero, 1600 ms when one.
// - Watchdog enable and period power-up defaults come from the memory.
// - Status bit 7 marks restore done, bit 6 store done.
// - Status bit 5 shows that a store is currently permitted.
// - Status bit 4 while restoring, bit 3 while storing.
// - Check failures: bit 2 rail group, bit 1 common, bit 0 either.
// - Code 66h restores all storable settings from the memory.
// - Code AAh saves current storable settings as new defaults.
// - Selector 02h common, 03h to 05h rails A to C; default 03h.
// - The selector exposes one channel's register set per value.
module icfg_port
   import icfg_pkg::*;
#(
   parameter int unsigned WD_SHORT = WD_SHORT_CYC,
   parameter int unsigned WD_P0 = WD_P0_CYC,
   parameter int unsigned WD_P1 = WD_P1_CYC,
   parameter logic [7:0] PART_CODE = 8'h5a, // Arbitrary value.
   parameter logic [7:0] VARIANT_CODE = 8'h0c // Arbitrary value.
)
(
   // Clock and reset.
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   // Serial bus pins and address strap.
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE_O,
   input wire logic [1:0] ADDR_SEL_I,
   // Non-volatile memory macro.
   output icfg_pkg::icfg_nvm_req_t NVM_REQ_O,
   input wire icfg_pkg::icfg_nvm_rsp_t NVM_RSP_I,
   // Selected rail window for the paged register banks.
   output logic [7:0] RAIL_SEL_O
);
   import icfg_pkg::*;

   typedef enum logic [8:0] {
      ST_IDLE = 9'b000000001,
      ST_ADDR = 9'b000000010,
      ST_AACK = 9'b000000100,
      ST_PTR = 9'b000001000,
      ST_PACK = 9'b000010000,
      ST_WR = 9'b000100000,
      ST_WACK = 9'b001000000,
      ST_RD = 9'b010000000,
      ST_RACK = 9'b100000000
   } icfg_state_t;

   // Synchronisers and edge history.
   logic scl_s1_r, scl_s2_r, scl_d_r;
   logic sda_s1_r, sda_s2_r, sda_d_r;
   logic [1:0] strap_s1_r, strap_s2_r;
   logic [1:0] strap_cnt_r;
   logic [6:0] my_addr_r;

   // Bit engine.
   icfg_state_t st_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r, tx_r, ptr_r;
   logic rw_r, nack_r, oe_r, busy_r;

   // Register file and write strobe.
   logic wr_stb_r;
   logic [7:0] wr_ofs_r, wr_dat_r;
   logic [1:0] wd_cfg_r;
   logic hang_r;
   logic [7:0] rail_r;

   // Watchdog.
   logic [WD_CNT_W-1:0] wd_cnt_r;

   // Sequencer links.
   logic [7:0] nv_status;
   logic seq_load;
   logic [1:0] seq_cfg, seq_dflt;

   // Read bytes for the current offset and for the one after it.
   logic [7:0] rd_byte, rd_follow;

   // Register read decode; used for the first and every following byte.
   function automatic logic [7:0] rd_mux(input logic [7:0] ofs);
      if (ofs == OFS_WATCHDOG)
         rd_mux = {hang_r, 5'h00, wd_cfg_r};
      else if (ofs == OFS_NV_STATUS)
         rd_mux = nv_status;
      else if (ofs == OFS_RAIL_SEL)
         rd_mux = rail_r;
      else if (ofs == OFS_PART)
         rd_mux = PART_CODE;
      else if (ofs == OFS_VARIANT)
         rd_mux = VARIANT_CODE;
      else
         rd_mux = ZERO_BYTE; // Command register is write-only.
   endfunction : rd_mux

   // Bus conditions, all taken from the second synchroniser stage on.
   wire scl_rise = scl_s2_r && !scl_d_r;
   wire scl_fall = !scl_s2_r && scl_d_r;
   wire bus_start = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
   wire bus_stop = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
   wire byte_end = scl_fall && (bit_cnt_r == 4'h8);
   wire [7:0] ptr_inc = ptr_r + 8'h01;
   wire addr_hit = (shift_r[7:1] == my_addr_r);

   // Kept in a process so the mux follows every register that it reads,
   // not only its offset argument.
   always_comb begin
      rd_byte = rd_mux(ptr_r);
      rd_follow = rd_mux(ptr_inc);
   end

   // Watchdog limit and expiry.
   wire wd_en = wd_cfg_r[WD_EN_BIT];
   wire [WD_CNT_W-1:0] wd_lim = !wd_en ? WD_CNT_W'(WD_SHORT - 1) :
      wd_cfg_r[WD_PER_BIT] ? WD_CNT_W'(WD_P1 - 1) :
      WD_CNT_W'(WD_P0 - 1);
   wire wd_fire = busy_r && (wd_cnt_r == wd_lim);
   wire wd_full = wd_fire && wd_en;

   // Register write decode.
   wire wr_wd = wr_stb_r && (wr_ofs_r == OFS_WATCHDOG);
   wire wr_rail = wr_stb_r && (wr_ofs_r == OFS_RAIL_SEL);
   wire wr_cmd = wr_stb_r && (wr_ofs_r == OFS_SAVE_CMD);

   // The pin is open drain, so the driven level is always low.
   assign SDA_O = 1'b0;
   assign SDA_OE_O = oe_r;
   assign RAIL_SEL_O = rail_r;

   // Two-flop synchronisers; sampling at 50 MHz leaves wide margin at
   // fast-mode rates, and the third stage only feeds edge detection.
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
         {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
      end else begin
         {scl_s1_r, scl_s2_r, scl_d_r} <= {SCL_I, scl_s1_r, scl_s2_r};
         {sda_s1_r, sda_s2_r, sda_d_r} <= {SDA_I, sda_s1_r, sda_s2_r};
      end
   end

   // The strap is loaded on the first three clocks after release; the last load, when the sync has settled, is kept.
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         strap_s1_r <= 2'h0;
         strap_s2_r <= 2'h0;
         strap_cnt_r <= 2'h0;
         my_addr_r <= TGT_ADDR_BASE;
      end else begin
         strap_s1_r <= ADDR_SEL_I;
         strap_s2_r <= strap_s1_r;
         if (strap_cnt_r != STRAP_WAIT) begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            my_addr_r <= TGT_ADDR_BASE | {5'h00, strap_s2_r};
         end
      end
   end

   // Bus-busy window and stall counter; any clock edge restarts it.
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         busy_r <= 1'b0;
         wd_cnt_r <= '0;
      end else begin
         if (bus_stop || wd_fire)
            busy_r <= 1'b0;
         else if (bus_start)
            busy_r <= 1'b1;
         if (!busy_r || scl_rise || scl_fall || bus_start)
            wd_cnt_r <= '0;
         else
            wd_cnt_r <= wd_cnt_r + WD_CNT_W'(1);
      end
   end

   // Serial bit engine. The clock line is never driven, so there is no
   // stretching; the host alone paces bits and bytes.
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         st_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= ZERO_BYTE;
         tx_r <= ZERO_BYTE;
         ptr_r <= ZERO_BYTE;
         rw_r <= 1'b0;
         nack_r <= 1'b0;
         oe_r <= 1'b0;
         wr_stb_r <= 1'b0;
         wr_ofs_r <= ZERO_BYTE;
         wr_dat_r <= ZERO_BYTE;
      end else begin
         wr_stb_r <= 1'b0;
         if (wd_fire || bus_stop) begin
            st_r <= ST_IDLE;
            oe_r <= 1'b0;
         end else if (bus_start) begin
            st_r <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            oe_r <= 1'b0;
         end else begin
            case (st_r)
               ST_ADDR, ST_PTR, ST_WR: begin
                  if (scl_rise) begin
                     shift_r <= {shift_r[6:0], sda_s2_r};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (byte_end) begin
                     bit_cnt_r <= 4'h0;
                     if (st_r == ST_ADDR) begin
                        oe_r <= addr_hit;
                        rw_r <= shift_r[0];
                        st_r <= addr_hit ? ST_AACK : ST_IDLE;
                     end else if (st_r == ST_PTR) begin
                        ptr_r <= shift_r;
                        oe_r <= 1'b1;
                        st_r <= ST_PACK;
                     end else begin
                        wr_stb_r <= 1'b1;
                        wr_ofs_r <= ptr_r;
                        wr_dat_r <= shift_r;
                        oe_r <= 1'b1;
                        st_r <= ST_WACK;
                     end
                  end
               end
               ST_AACK: begin
                  if (scl_fall && rw_r) begin
                     tx_r <= rd_byte;
                     oe_r <= !rd_byte[7];
                     bit_cnt_r <= 4'h1;
                     st_r <= ST_RD;
                  end else if (scl_fall) begin
                     oe_r <= 1'b0;
                     st_r <= ST_PTR;
                  end
               end
               ST_PACK, ST_WACK: begin
                  if (scl_fall) begin
                     oe_r <= 1'b0;
                     if (st_r == ST_WACK)
                        ptr_r <= ptr_inc;
                     st_r <= ST_WR;
                  end
               end
               ST_RD: begin
                  if (byte_end) begin
                     oe_r <= 1'b0;
                     bit_cnt_r <= 4'h0;
                     st_r <= ST_RACK;
                  end else if (scl_fall) begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     oe_r <= !tx_r[6];
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
               ST_RACK: begin
                  if (scl_rise)
                     nack_r <= sda_s2_r;
                  else if (scl_fall && nack_r)
                     st_r <= ST_IDLE;
                  else if (scl_fall) begin
                     ptr_r <= ptr_inc;
                     tx_r <= rd_follow;
                     oe_r <= !rd_follow[7];
                     bit_cnt_r <= 4'h1;
                     st_r <= ST_RD;
                  end
               end
               default: st_r <= ST_IDLE;
            endcase
         end
      end
   end

   // Register file. A full watchdog reset wins over everything and
   // returns the stored defaults; the hang flag survives it.
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         wd_cfg_r <= WD_CFG_RST;
         rail_r <= RAIL_SEL_RST;
      end else if (wd_full) begin
         wd_cfg_r <= seq_dflt;
         rail_r <= RAIL_SEL_RST;
      end else if (seq_load) begin
         wd_cfg_r <= seq_cfg;
      end else begin
         if (wr_wd)
            wd_cfg_r <= wr_dat_r[1:0];
         if (wr_rail)
            rail_r <= wr_dat_r & RAIL_SEL_MASK;
      end
   end

   // Hang flag: set by the watchdog, cleared when a live transaction ends
   // with a stop. Clearing at the start would hide it from the very read
   // that asks for it. The set wins if both arrive together.
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I)
         hang_r <= 1'b0;
      else if (wd_fire)
         hang_r <= 1'b1;
      else if (bus_stop && busy_r)
         hang_r <= 1'b0;
   end

   // Store/restore sequencer; command codes are filtered inside.
   icfg_nvm_seq u_seq (
      .clk_i(CLOCK_I),
      .rst_n_i(RESETN_I),
      .cmd_stb_i(wr_cmd),
      .cmd_code_i(wr_dat_r),
      .cur_cfg_i(wd_cfg_r),
      .rsp_i(NVM_RSP_I),
      .req_o(NVM_REQ_O),
      .status_o(nv_status),
      .load_o(seq_load),
      .load_cfg_o(seq_cfg),
      .dflt_o(seq_dflt)
   );

endmodule : icfg_port
`default_nettype wire

// *** sim/icfg_port_properties.sv ***
/*
 Checker for the configuration port, bound to every icfg_port.
 Assumes a memory partner that answers each request with one pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module icfg_port_properties
   import icfg_pkg::*;
(
   // Watched ports.
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   input wire logic SCL_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_O,
   input wire icfg_pkg::icfg_nvm_req_t NVM_REQ_O,
   input wire icfg_pkg::icfg_nvm_rsp_t NVM_RSP_I,
   input wire logic [7:0] RAIL_SEL_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   // The power-up restore read follows the release of reset.
   sequence boot_s;
      $rose(RESETN_I);
   endsequence
   sequence load_s;
      ##[1:3] (NVM_REQ_O.req && !NVM_REQ_O.write);
   endsequence
   a_boot_restore: assert property (boot_s |-> load_s)
      else $error("no restore after reset");
   a_reset_quiet: assert property (disable iff (1'b0)
      !RESETN_I |-> !SDA_OE_O && !NVM_REQ_O.req && RAIL_SEL_O == 8'h03)
      else $error("outputs active during reset");
   a_req_hold: assert property (NVM_REQ_O.req && !NVM_RSP_I.ack
      |=> NVM_REQ_O.req && $stable(NVM_REQ_O))
      else $error("request changed before answer");
   a_req_release: assert property (NVM_REQ_O.req && NVM_RSP_I.ack
      |=> !NVM_REQ_O.req) else $error("request held after answer");
   a_store_payload: assert property (NVM_REQ_O.req && NVM_REQ_O.write
      |-> NVM_REQ_O.data[7:2] == 6'h00) else $error("store payload wide");
   a_store_allowed: assert property ($rose(NVM_REQ_O.req)
      && NVM_REQ_O.write |-> NVM_RSP_I.store_allow)
      else $error("store started without permission");
   // Open drain: the driven level is low, moved only while the clock is low.
   a_sda_level: assert property (SDA_O == 1'b0)
      else $error("data pin driven high");
   a_oe_scl_low: assert property ($changed(SDA_OE_O) |-> !SCL_I)
      else $error("data moved with clock high");
   a_sel_scl_low: assert property ($changed(RAIL_SEL_O) |-> !SCL_I)
      else $error("selector moved with clock high");
   a_sel_range: assert property (RAIL_SEL_O[7:3] == 5'h00)
      else $error("selector upper bits set");
endmodule : icfg_port_properties
bind icfg_port icfg_port_properties u_icfg_port_properties (
   .CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .SCL_I(SCL_I), .SDA_O(SDA_O),
   .SDA_OE_O(SDA_OE_O), .NVM_REQ_O(NVM_REQ_O), .NVM_RSP_I(NVM_RSP_I),
   .RAIL_SEL_O(RAIL_SEL_O));
`default_nettype wire

// *** sim/icfg_host.sv ***
/*
 Behavioural two-wire bus controller that paces every bit itself.
 Assumes pull-ups on both lines and an open-drain target on data.
*/
`timescale 1ns/1ps
`default_nettype none
module icfg_host #(
   parameter int Q = 32
)
(
   // Clock and line levels.
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   // Both lines idle high; a bit of 4*Q clocks stays within fast mode.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic qw;
      repeat (Q) @(negedge clk_i);
   endtask : qw
   // Start or repeated start: data falls while the clock is high.
   task automatic start;
      sda_o = 1'b1;
      qw();
      scl_o = 1'b1;
      qw();
      sda_o = 1'b0;
      qw();
      scl_o = 1'b0;
      qw();
   endtask : start
   task automatic stop;
      sda_o = 1'b0;
      qw();
      scl_o = 1'b1;
      qw();
      sda_o = 1'b1;
      qw();
   endtask : stop
   // Data changes only a quarter bit after the fall, clear of the target.
   task automatic bit_x(input logic b, output logic s);
      sda_o = b;
      qw();
      scl_o = 1'b1;
      qw();
      s = sda_i;
      qw();
      scl_o = 1'b0;
      qw();
   endtask : bit_x
   // Byte out, first bit the top one; returns the target's acknowledge.
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(d[i], s);
      bit_x(1'b1, s);
      ack = !s;
   endtask : put
   // Byte in, then acknowledge or, on the last byte, refuse.
   task automatic get(output logic [7:0] d, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(last, s);
   endtask : get
endmodule : icfg_host
`default_nettype wire

// *** sim/tb_icfg_port.sv ***
/*
 Self-checking bench for icfg_port with a host model and a memory model.
 Assumes the checker is attached by the bind in its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_icfg_port;
   import icfg_pkg::*;
   localparam int Q = 32;
   localparam int unsigned WS = 200;
   localparam int unsigned W0 = 400;
   localparam int unsigned W1 = 800;
   localparam logic [7:0] PC = 8'h3c; // Arbitrary value.
   localparam logic [7:0] VC = 8'h5e; // Arbitrary value.
   logic clk = 1'b0;
   logic rst_n = 1'b1;
   logic [1:0] strap = 2'h0;
   logic [6:0] ta;
   logic sda_o, sda_oe, a;
   logic [7:0] rail_sel;
   wire logic scl;
   wire logic h_sda;
   wire logic sda = h_sda & (sda_oe ? sda_o : 1'b1);
   icfg_nvm_req_t req;
   logic ack = 1'b0;
   logic allow = 1'b1;
   logic [1:0] cf = 2'h0;
   logic [7:0] nv = 8'h03;
   int lat = 0;
   int nlat = 10;
   // Outside the answer the memory shows inverted data, never a stale copy.
   wire icfg_nvm_rsp_t rsp = {ack, ack ? nv : ~nv, ack ? cf : ~cf, allow};
   logic m_rd = 1'b0;
   logic m_sd = 1'b0;
   logic [1:0] m_cf = 2'h0;
   logic [7:0] codes [4] = '{8'h02, 8'h03, 8'h04, 8'hff};
   logic [16:0] lf = 17'h12c91;
   int error_cnt = 0;
   int check_count = 0;

   always #10 clk = ~clk;

   icfg_port #(.WD_SHORT(WS), .WD_P0(W0), .WD_P1(W1), .PART_CODE(PC),
      .VARIANT_CODE(VC)) u_icfg_port (
      .CLOCK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda),
      .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ADDR_SEL_I(strap),
      .NVM_REQ_O(req), .NVM_RSP_I(rsp), .RAIL_SEL_O(rail_sel));
   icfg_host #(.Q(Q)) u_icfg_host (
      .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(h_sda));

   // Memory answers a held request after nlat cycles and keeps a store.
   always @(negedge clk) begin
      ack <= 1'b0;
      if (req.req === 1'b1 && !ack) begin
         if (lat >= nlat) begin
            ack <= 1'b1;
            lat <= 0;
            if (req.write) nv <= req.data;
         end else lat <= lat + 1;
      end
   end

   function automatic logic [16:0] lfsr(input logic [16:0] x);
      return {x[15:0], x[16] ^ x[13]};
   endfunction : lfsr
   // Expected status byte from the bench's own flags.
   function automatic logic [7:0] st(input logic rb, input logic sb);
      return {m_rd, m_sd, allow, rb, sb, m_cf, |m_cf};
   endfunction : st
   task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic a0, a1, a2;
      u_icfg_host.start();
      u_icfg_host.put({ta, 1'b0}, a0);
      u_icfg_host.put(idx, a1);
      u_icfg_host.put(d, a2);
      u_icfg_host.stop();
      check("write_ack", {a0, a1, a2}, 3'h7);
   endtask : wr
   // Burst read of n bytes from idx, compared with exp.
   task automatic rdc(input logic [7:0] idx, input int n,
      input logic [31:0] exp);
      logic a0, a1, a2;
      logic [7:0] b;
      logic [31:0] d;
      d = '0;
      u_icfg_host.start();
      u_icfg_host.put({ta, 1'b0}, a0);
      u_icfg_host.put(idx, a1);
      u_icfg_host.start();
      u_icfg_host.put({ta, 1'b1}, a2);
      for (int i = 0; i < n; i++) begin
         u_icfg_host.get(b, i == n - 1);
         d = {d[23:0], b};
      end
      u_icfg_host.stop();
      check("read_ack", {a0, a1, a2}, 3'h7);
      check("read_data", d, exp);
   endtask : rdc
   task automatic wait_nv;
      int n;
      n = 0;
      while (req.req !== 1'b0 && n < 9000) begin
         @(negedge clk);
         n++;
      end
      check("nv_idle", req.req, 1'b0);
   endtask : wait_nv
   // Stall after the address byte; lim 0 means no register reset expected.
   task automatic stall(input int lim, input logic [7:0] sel);
      logic k, ok;
      int n;
      n = 0;
      u_icfg_host.start();
      u_icfg_host.put({ta, 1'b0}, k);
      while (n < 1000 && rail_sel !== 8'h03) begin
         @(negedge clk);
         n++;
      end
      u_icfg_host.stop();
      ok = (lim == 0) ? (n == 1000) : (n >= lim - Q - 2 && n <= lim - Q + 8);
      check("wd_time", {ok, rail_sel}, {1'b1, lim == 0 ? sel : 8'h03});
   endtask : stall

   // A hang cuts the run short through the same verdict.
   initial begin
      #2_400_000;
      error_cnt++;
      final_report();
   end

   // Main sequence.
   initial begin
      #1;
      rst_n = 1'b0;
      strap = lf[1:0];
      ta = 7'h20 | {5'h00, strap};
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      wait_nv();
      u_icfg_host.start();
      u_icfg_host.put({ta ^ 7'h01, 1'b0}, a);
      u_icfg_host.stop();
      check("wrong_addr", a, 1'b0);
      rdc(8'hdf, 1, 32'h03);
      rdc(8'hec, 4, {st(0, 0), 8'h00, 8'h00, 8'h03});
      rdc(8'hfb, 2, {PC, VC});
      foreach (codes[i]) begin
         wr(8'hef, codes[i]);
         check("rail_sel", rail_sel, codes[i] & 8'h07);
      end
      lf = lfsr(lf);
      nv = lf[7:0];
      cf = lf[9:8];
      nlat = 5000;
      wr(8'hed, 8'h66);
      rdc(8'hec, 1, st(1, 0));
      wait_nv();
      m_rd = 1'b1;
      m_cf = cf;
      rdc(8'hec, 1, st(0, 0));
      rdc(8'hdf, 1, {30'h0, nv[1:0]});
      allow = 1'b0;
      wr(8'hed, 8'h55);
      rdc(8'hec, 1, st(0, 0));
      allow = 1'b1;
      wr(8'hdf, 8'hfe);
      wr(8'hed, 8'haa);
      m_rd = 1'b0;
      rdc(8'hec, 1, st(0, 1));
      wait_nv();
      m_sd = 1'b1;
      rdc(8'hec, 1, st(0, 0));
      check("stored", nv, 8'h02);
      wr(8'hdf, 8'h00);
      stall(0, 8'h07);
      wr(8'hdf, 8'h03);
      stall(W1, 8'h07);
      wr(8'hef, 8'h05);
      stall(W0, 8'h05);
      rdc(8'hdf, 1, 32'h82);
      final_report();
   end
endmodule : tb_icfg_port
`default_nettype wire
